// [nsw_defines.svh]
`ifndef NSW_DEFINES_SVH
`define NSW_DEFINES_SVH

// register indices; the byte address is four times the index
`define NSW_IDX_ERR 6'h13
`define NSW_IDX_REG 6'h14
`define NSW_IDX_PRES 6'h15
`define NSW_IDX_HIST 6'h16

// error word bit positions
`define NSW_BIT_PARAM 4
`define NSW_BIT_FRAME 5
`define NSW_BIT_LINK 9
`define NSW_BIT_DUP 10
`define NSW_BIT_INIT 11
`define NSW_BIT_AL 12
`define NSW_BIT_PD_NF 14
`define NSW_BIT_PD_F 15
`define NSW_ERR_UNUSED_MASK 16'h21c0

// reset values
`define NSW_WORD_RST 16'h0000
`define NSW_DATA_RST 32'h0000_0000

// axi response codes
`define NSW_RESP_OKAY 2'h0
`define NSW_RESP_SLVERR 2'h2

`endif

// [nsw_pkg.sv]
package nsw_pkg;

    typedef logic [15:0] nsw_word_t;

    // live conditions reported by the fieldbus master engine
    typedef struct packed {
        logic pd_fatal;
        logic pd_nonfatal;
        logic al_status_err;
        logic slave_init_err;
        logic addr_dup;
        logic link_err;
        logic frame_send_err;
        logic param_err;
        nsw_word_t present_nodes;
        nsw_word_t reg_nodes;
    } nsw_cond_t;

endpackage

// [nsw_sync2.sv]
`timescale 1ns/1ns
`default_nettype none

module nsw_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_reg;
    logic [W-1:0] q_next;

    generate
        if (W < 1) begin : g_bad_width
            $error("nsw_sync2: width must be at least one");
        end
    endgenerate

    // first stage feeds only the second stage
    always_comb begin
        meta_next = d;
        q_next = meta_reg;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule

`default_nettype wire

// [nsw_status_bank.sv]
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "nsw_defines.svh"

module nsw_status_bank #(
    parameter int ADDR_W = 8,
    parameter int NODES = 16
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // axi4-lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // axi4-lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // live conditions from the fieldbus master engine, asynchronous
    input wire nsw_pkg::nsw_cond_t cond
);

    generate
        if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
            $error("nsw_status_bank: address width must be 8 to 32");
        end
        if (NODES < 1 || NODES > 16) begin : g_bad_nodes
            $error("nsw_status_bank: node count must be 1 to 16");
        end
    endgenerate

    // synchronised conditions
    nsw_pkg::nsw_cond_t cs;

    nsw_sync2 #(
        .W($bits(nsw_pkg::nsw_cond_t))
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(cond),
        .q(cs)
    );

    // status words
    nsw_pkg::nsw_word_t err_word_reg;
    nsw_pkg::nsw_word_t err_word_next;
    nsw_pkg::nsw_word_t reg_tab_reg;
    nsw_pkg::nsw_word_t reg_tab_next;
    nsw_pkg::nsw_word_t pres_tab_reg;
    nsw_pkg::nsw_word_t pres_tab_next;
    nsw_pkg::nsw_word_t hist_reg;
    nsw_pkg::nsw_word_t hist_next;
    nsw_pkg::nsw_word_t hist_clr;

    always_comb begin
        err_word_next = `NSW_WORD_RST;
        err_word_next[`NSW_BIT_PARAM] = cs.param_err;
        err_word_next[`NSW_BIT_FRAME] = cs.frame_send_err;
        err_word_next[`NSW_BIT_LINK] = cs.link_err;
        err_word_next[`NSW_BIT_DUP] = cs.addr_dup;
        err_word_next[`NSW_BIT_INIT] = cs.slave_init_err;
        err_word_next[`NSW_BIT_AL] = cs.al_status_err;
        err_word_next[`NSW_BIT_PD_NF] = cs.pd_nonfatal;
        err_word_next[`NSW_BIT_PD_F] = cs.pd_fatal;
        // unused bits stay at zero whatever is written
        err_word_next = err_word_next & ~`NSW_ERR_UNUSED_MASK;
    end

    // node tables: nodes beyond the configured count read as absent
    genvar k;
    generate
        for (k = 0; k < 16; k++) begin : g_node
            if (k < NODES) begin : g_used
                assign reg_tab_next[k] = cs.reg_nodes[k];
                assign pres_tab_next[k] = cs.present_nodes[k];
            end else begin : g_unused
                assign reg_tab_next[k] = 1'b0;
                assign pres_tab_next[k] = 1'b0;
            end
        end
    endgenerate

    // write channel state
    logic awready_reg;
    logic awready_next;
    logic wready_reg;
    logic wready_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic have_aw_reg;
    logic have_aw_next;
    logic have_w_reg;
    logic have_w_next;
    logic [ADDR_W-1:0] waddr_reg;
    logic [ADDR_W-1:0] waddr_next;
    logic [31:0] wdata_reg;
    logic [31:0] wdata_next;
    logic [3:0] wstrb_reg;
    logic [3:0] wstrb_next;
    logic wr_fire;
    logic wr_hit_status;
    logic wr_hit_hist;

    function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
        hits = (a[7:2] == idx) && ((a >> 8) == '0);
    endfunction

    always_comb begin
        awready_next = awready_reg;
        wready_next = wready_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        have_aw_next = have_aw_reg;
        have_w_next = have_w_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        wr_fire = 1'b0;
        wr_hit_status = 1'b0;
        wr_hit_hist = 1'b0;
        if (bvalid_reg && bready) begin
            bvalid_next = 1'b0;
        end
        if (awvalid && awready_reg) begin
            have_aw_next = 1'b1;
            waddr_next = awaddr;
        end
        if (wvalid && wready_reg) begin
            have_w_next = 1'b1;
            wdata_next = wdata;
            wstrb_next = wstrb;
        end
        // both halves held: answer once, one cycle after the later half
        if (have_aw_reg && have_w_reg && !bvalid_reg) begin
            wr_fire = 1'b1;
            have_aw_next = 1'b0;
            have_w_next = 1'b0;
            bvalid_next = 1'b1;
            wr_hit_status = hits(waddr_reg, `NSW_IDX_ERR) || hits(waddr_reg, `NSW_IDX_REG)
                || hits(waddr_reg, `NSW_IDX_PRES);
            wr_hit_hist = hits(waddr_reg, `NSW_IDX_HIST);
            // status words accept the write silently and keep live values
            bresp_next = (wr_hit_status || wr_hit_hist) ? `NSW_RESP_OKAY : `NSW_RESP_SLVERR;
        end
        awready_next = !have_aw_next && !bvalid_next;
        wready_next = !have_w_next && !bvalid_next;
    end

    // error history: sticky copy of the error word, write one to clear
    always_comb begin
        hist_clr = `NSW_WORD_RST;
        if (wr_fire && wr_hit_hist) begin
            hist_clr[7:0] = wstrb_reg[0] ? wdata_reg[7:0] : 8'h00;
            hist_clr[15:8] = wstrb_reg[1] ? wdata_reg[15:8] : 8'h00;
        end
        // a live error in the clearing cycle keeps its bit set
        hist_next = (hist_reg & ~hist_clr) | err_word_reg;
    end

    // read channel state
    logic arready_reg;
    logic arready_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && rready) begin
            rvalid_next = 1'b0;
        end
        if (arvalid && arready_reg) begin
            rvalid_next = 1'b1;
            rresp_next = `NSW_RESP_OKAY;
            if (hits(araddr, `NSW_IDX_ERR)) begin
                rdata_next = {16'h0000, err_word_reg};
            end else if (hits(araddr, `NSW_IDX_REG)) begin
                rdata_next = {16'h0000, reg_tab_reg};
            end else if (hits(araddr, `NSW_IDX_PRES)) begin
                rdata_next = {16'h0000, pres_tab_reg};
            end else if (hits(araddr, `NSW_IDX_HIST)) begin
                rdata_next = {16'h0000, hist_reg};
            end else begin
                rdata_next = `NSW_DATA_RST;
                rresp_next = `NSW_RESP_SLVERR;
            end
        end
        arready_next = !rvalid_next;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_word_reg <= `NSW_WORD_RST;
            reg_tab_reg <= `NSW_WORD_RST;
            pres_tab_reg <= `NSW_WORD_RST;
            hist_reg <= `NSW_WORD_RST;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `NSW_RESP_OKAY;
            have_aw_reg <= 1'b0;
            have_w_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= `NSW_DATA_RST;
            wstrb_reg <= 4'h0;
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= `NSW_DATA_RST;
            rresp_reg <= `NSW_RESP_OKAY;
        end else begin
            err_word_reg <= err_word_next;
            reg_tab_reg <= reg_tab_next;
            pres_tab_reg <= pres_tab_next;
            hist_reg <= hist_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            have_aw_reg <= have_aw_next;
            have_w_reg <= have_w_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            arready_reg <= arready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign awready = awready_reg;
    assign wready = wready_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign arready = arready_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // a condition at the pins shows in the word three edges later
    property p_param;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn, 3) |-> err_word_reg[`NSW_BIT_PARAM] == $past(cond.param_err, 3);
    endproperty
    a_param: assert property (p_param) else $error("param flag wrong");

    property p_frame;
        @(posedge aclk) disable iff (!aresetn)
        $rose(cs.frame_send_err) |=> err_word_reg[`NSW_BIT_FRAME];
    endproperty
    a_frame: assert property (p_frame) else $error("frame flag not set");

    property p_link;
        @(posedge aclk) disable iff (!aresetn)
        $fell(cs.link_err) |=> !err_word_reg[`NSW_BIT_LINK];
    endproperty
    a_link: assert property (p_link) else $error("link flag not cleared");

    property p_dup;
        @(posedge aclk) disable iff (!aresetn)
        cs.addr_dup [*2] |=> err_word_reg[`NSW_BIT_DUP] && $past(err_word_reg[`NSW_BIT_DUP]);
    endproperty
    a_dup: assert property (p_dup) else $error("duplicate flag wrong");

    property p_init;
        @(posedge aclk) disable iff (!aresetn)
        $changed(err_word_reg[`NSW_BIT_INIT])
            |-> $past(cs.slave_init_err) != $past(err_word_reg[`NSW_BIT_INIT]);
    endproperty
    a_init: assert property (p_init) else $error("init flag changed alone");

    property p_al;
        @(posedge aclk) disable iff (!aresetn)
        cs.al_status_err |=> err_word_reg[`NSW_BIT_AL];
    endproperty
    a_al: assert property (p_al) else $error("al flag not set");

    property p_pd_nf;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn, 3) |-> err_word_reg[`NSW_BIT_PD_NF] == $past(cond.pd_nonfatal, 3);
    endproperty
    a_pd_nf: assert property (p_pd_nf) else $error("non-fatal flag wrong");

    property p_pd_f;
        @(posedge aclk) disable iff (!aresetn)
        !cs.pd_fatal |=> !err_word_reg[`NSW_BIT_PD_F];
    endproperty
    a_pd_f: assert property (p_pd_f) else $error("fatal flag stuck");

    property p_reg_tab;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn, 3) |-> reg_tab_reg[NODES-1:0] == $past(cond.reg_nodes[NODES-1:0], 3);
    endproperty
    a_reg_tab: assert property (p_reg_tab) else $error("registered table wrong");

    property p_pres_tab;
        @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> pres_tab_reg[NODES-1:0] == $past(cs.present_nodes[NODES-1:0]);
    endproperty
    a_pres_tab: assert property (p_pres_tab) else $error("presence table wrong");

    property p_unused;
        @(posedge aclk) disable iff (!aresetn)
        rvalid_reg && rresp_reg == `NSW_RESP_OKAY && $past(arvalid && arready_reg
            && hits(araddr, `NSW_IDX_ERR))
            |-> (rdata_reg[15:0] & `NSW_ERR_UNUSED_MASK) == 16'h0000;
    endproperty
    a_unused: assert property (p_unused) else $error("unused error bits set");

    property p_no_write;
        @(posedge aclk) disable iff (!aresetn)
        wr_fire && wr_hit_status && $stable(cs) |=> err_word_reg == $past(err_word_reg)
            && reg_tab_reg == $past(reg_tab_reg) && pres_tab_reg == $past(pres_tab_reg)
            && bvalid_reg && bresp_reg == `NSW_RESP_OKAY;
    endproperty
    a_no_write: assert property (p_no_write) else $error("status word took a write");

    property p_read_live;
        @(posedge aclk) disable iff (!aresetn)
        arvalid && arready_reg && hits(araddr, `NSW_IDX_ERR)
            |=> rvalid_reg && rdata_reg == {16'h0000, $past(err_word_reg)};
    endproperty
    a_read_live: assert property (p_read_live) else $error("read of error word wrong");

endmodule

`default_nettype wire

// [nsw_net_model.sv]
`timescale 1ns/1ns
`default_nettype none

module nsw_net_model (
    // clock
    input wire logic aclk,
    // what the bench wants the network to look like
    input wire logic [7:0] fault_set,
    input wire logic [15:0] cfg_nodes,
    input wire logic [15:0] live_nodes,
    // live conditions as the master engine reports them
    output var nsw_pkg::nsw_cond_t cond
);
    // a quiet network before the first edge, so the bank never sees unknowns
    initial cond = '0;

    // conditions move just after an edge, never on it
    always @(posedge aclk) begin
        cond <= {fault_set, live_nodes, cfg_nodes};
    end
endmodule

`default_nettype wire

// [test_network_status_word_bank.sv]
`timescale 1ns/1ns
`default_nettype none
`include "nsw_defines.svh"

module test_network_status_word_bank;
    localparam logic [7:0] A_ERR = {`NSW_IDX_ERR, 2'b00};
    localparam logic [7:0] A_REG = {`NSW_IDX_REG, 2'b00};
    localparam logic [7:0] A_PRES = {`NSW_IDX_PRES, 2'b00};
    localparam logic [7:0] A_HIST = {`NSW_IDX_HIST, 2'b00};
    localparam logic [1:0] OKAY = 2'h0;
    localparam logic [1:0] SLVERR = 2'h2;

    logic aclk, aresetn;
    logic [7:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [7:0] fault_set;
    logic [15:0] cfg_nodes, live_nodes;
    nsw_pkg::nsw_cond_t cond;
    int fail_count = 0;
    int total_checks = 0;
    // error word position of each fault, in fault_set order
    int pos[8] = '{4, 5, 9, 10, 11, 12, 14, 15};

    nsw_status_bank i_nsw_status_bank (
        .aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .cond(cond)
    );

    nsw_net_model i_nsw_net_model (
        .aclk(aclk), .fault_set(fault_set), .cfg_nodes(cfg_nodes),
        .live_nodes(live_nodes), .cond(cond)
    );

    initial aclk = 1'b0;
    always #10 aclk = ~aclk;

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] exp_resp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        while (!arready) @(posedge aclk);
        arvalid <= 1'b0;
        @(posedge aclk);
        while (!rvalid) @(posedge aclk);
        rready <= 1'b0;
        check(what, exp, rdata);
        check({what, " resp"}, {30'h0, exp_resp}, {30'h0, rresp});
        // let an edge pass so a following call never re-drives rready in this step
        @(posedge aclk);
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] exp_resp);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // slave may take the two channels in either order
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        @(posedge aclk);
        while (!bvalid) @(posedge aclk);
        bready <= 1'b0;
        check("write resp", {30'h0, exp_resp}, {30'h0, bresp});
        @(posedge aclk);
    endtask

    // model edge plus two synchroniser flops plus the register, with margin
    task automatic settle();
        repeat (6) @(posedge aclk);
    endtask

    task print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        $display("[FAIL] watchdog expected done seen hang");
        print_verdict();
    end

    initial begin
        aresetn = 1'b0;
        awaddr = '0;
        araddr = '0;
        awprot = '0;
        arprot = '0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        wdata = '0;
        wstrb = '0;
        fault_set = '0;
        cfg_nodes = '0;
        live_nodes = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd_chk("err idle", A_ERR, 32'h0, OKAY);
        for (int i = 0; i < 8; i++) begin
            fault_set <= 8'h01 << i;
            settle();
            if (i < 4) begin
                rd_chk("err low", A_ERR, 32'h1 << pos[i], OKAY);
            end else begin
                rd_chk("err high", A_ERR, 32'h1 << pos[i], OKAY);
            end
        end
        fault_set <= 8'hff;
        settle();
        rd_chk("err all", A_ERR, 32'h0000_de30, OKAY);
        wr_chk(A_ERR, 32'hffff_ffff, 4'hf, OKAY);
        rd_chk("err after ones", A_ERR, 32'h0000_de30, OKAY);
        wr_chk(A_ERR, 32'h0000_0000, 4'hf, OKAY);
        rd_chk("err after zeros", A_ERR, 32'h0000_de30, OKAY);
        fault_set <= 8'h00;
        settle();
        rd_chk("err cleared", A_ERR, 32'h0, OKAY);
        // history keeps what the live word dropped; cleared one lane at a time
        rd_chk("hist", A_HIST, 32'h0000_de30, OKAY);
        wr_chk(A_HIST, 32'h0000_00ff, 4'h1, OKAY);
        rd_chk("hist low", A_HIST, 32'h0000_de00, OKAY);
        wr_chk(A_HIST, 32'h0000_ff00, 4'h1, OKAY);
        rd_chk("hist gated", A_HIST, 32'h0000_de00, OKAY);
        wr_chk(A_HIST, 32'h0000_ff00, 4'h2, OKAY);
        rd_chk("hist high", A_HIST, 32'h0, OKAY);
        for (int k = 0; k < 16; k++) begin
            cfg_nodes <= 16'h1 << k;
            live_nodes <= ~(16'h1 << k);
            settle();
            rd_chk("registered", A_REG, {16'h0, 16'h1 << k}, OKAY);
            rd_chk("present", A_PRES, {16'h0, ~(16'h1 << k)}, OKAY);
        end
        wr_chk(A_REG, 32'h0000_0000, 4'hf, OKAY);
        wr_chk(A_PRES, 32'h0000_ffff, 4'hf, OKAY);
        rd_chk("registered kept", A_REG, 32'h0000_8000, OKAY);
        rd_chk("present kept", A_PRES, 32'h0000_7fff, OKAY);
        rd_chk("unmapped above", 8'h5c, 32'h0, SLVERR);
        rd_chk("unmapped below", 8'h48, 32'h0, SLVERR);
        wr_chk(8'h5c, 32'h0000_ffff, 4'hf, SLVERR);
        print_verdict();
    end
endmodule

`default_nettype wire
